// ---- inc/two_wire_bus_pkg.sv ----
// package: constants and carrier types for the two-wire bus framing block
package two_wire_bus_pkg;

	localparam int          ADDR_BITS        = 7;
	localparam int          BYTE_BITS        = 8;
	localparam logic [3:0]  LAST_BIT_INDEX   = 4'h8;
	localparam logic [6:0]  GENERAL_CALL_ADR = 7'h00;
	localparam logic [3:0]  RESERVED_TOP     = 4'hf;
	localparam logic [6:0]  OWN_ADDR_RESET   = 7'h10;
	localparam logic        DIR_READ         = 1'b1;
	localparam logic        DIR_WRITE        = 1'b0;

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_ADDR,
		PH_DATA,
		PH_IGNORE
	} phase_t;

	// one open-drain line at the port
	typedef struct packed {
		logic out;
		logic oe;
	} od_pin_t;

	// what the user side sees after a byte
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       isAddress;
		logic       generalCall;
		logic       readDir;
	} rx_event_t;

	typedef struct packed {
		logic [1:0]  sclSync;
		logic [1:0]  sdaSync;
		logic        sclPrev;
		logic        sdaPrev;
		logic        busBusy;
		phase_t      phase;
		logic [3:0]  bitIndex;
		logic [7:0]  shift;
		logic        addressed;
		logic        readMode;
		logic        generalCall;
		logic        sdaLow;
		logic        masterAck;
		logic [7:0]  txByte;
		logic        startSeen;
		logic        stopSeen;
		rx_event_t   rx;
	} state_t;

endpackage

// ---- core/two_wire_bus_slave.sv ----
// slave-side framing engine of the two-wire bus: conditions, busy, address and data packets
//
// Overview of operation
// - the master starts, ends and clocks every transfer; this end only follows it
// - one clock pulse per bit; data is sampled on the rising clock edge
// - data edges while clock is high are decoded as start or stop
// - bus is busy from a start until the next stop
// - a start while busy is a repeated start; busy stays until stop
// - address packet is seven address bits, direction bit, acknowledge slot
// - direction one means read, zero means write
// - matching slave pulls data low in the ninth clock period
// - busy or unable slave leaves data released in the acknowledge slot
// - address byte arrives most significant bit first
// - all-zero address is the general call, never an own address
// - general call write is acknowledged when enabled; following data received
// - addresses 1111xxx are reserved and never an own address
// - lines are only pulled low or released; wired-AND level is read
// - data packets are a byte msb first plus receiver acknowledge
module two_wire_bus_slave
	import two_wire_bus_pkg::*;
(
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// control
	input  wire logic       two_wire_power_gate,
	input  wire logic [6:0] ownAddress,
	input  wire logic       generalCallEnable,
	input  wire logic       slaveReady,
	input  wire logic [7:0] txData,
	// bus pins
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	output od_pin_t         sclPin,
	output od_pin_t         sdaPin,
	// status
	output logic            busBusy,
	output logic            startDetected,
	output logic            stopDetected,
	output rx_event_t       rxEvent
);

	// whole state in one register; next_s is its combinational copy
	state_t s;
	state_t next_s;

	// reserved or general call addresses never match as own address
	function automatic logic ownAddrLegal(input logic [6:0] a);
		return (a != GENERAL_CALL_ADR) && (a[6:3] != RESERVED_TOP);
	endfunction

	// both packet kinds are clocked the same way; idle and ignore are not
	function automatic logic inFrame(input phase_t p);
		return (p == PH_ADDR) || (p == PH_DATA);
	endfunction

	// pulse count once the acknowledge slot has been clocked
	function automatic logic [3:0] afterAck();
		return LAST_BIT_INDEX + 4'h1;
	endfunction

	// bit of a read byte that goes out once the given pulses have passed
	function automatic logic txBitAt(input logic [7:0] b, input logic [3:0] sent);
		logic [3:0] pos;
		pos = LAST_BIT_INDEX - 4'h1 - sent;
		return b[pos[2:0]];
	endfunction

	logic sclNow;
	logic sdaNow;
	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;

	// pins are asynchronous: two flops each before any decode, and the
	// previous synchronised level gives the edges one cycle later
	always_comb
	begin
		sclNow    = s.sclSync[1];
		sdaNow    = s.sdaSync[1];
		sclRise   = sclNow & ~s.sclPrev;
		sclFall   = ~sclNow & s.sclPrev;
		startCond = sclNow & s.sclPrev & s.sdaPrev & ~sdaNow;
		stopCond  = sclNow & s.sclPrev & ~s.sdaPrev & sdaNow;
	end

	always_comb
	begin
		next_s            = s;
		next_s.sclSync    = {s.sclSync[0], sclIn};
		next_s.sdaSync    = {s.sdaSync[0], sdaIn};
		next_s.sclPrev    = sclNow;
		next_s.sdaPrev    = sdaNow;
		next_s.startSeen  = 1'b0;
		next_s.stopSeen   = 1'b0;
		next_s.rx.valid   = 1'b0;

		if (two_wire_power_gate)
		begin
			// gated: ignore the bus entirely and let go of the data line
			next_s.busBusy   = 1'b0;
			next_s.phase     = PH_IDLE;
			next_s.sdaLow    = 1'b0;
			next_s.addressed = 1'b0;
		end
		else if (startCond)
		begin
			// covers repeated start too: busy simply stays set
			next_s.busBusy   = 1'b1;
			next_s.startSeen = 1'b1;
			next_s.phase     = PH_ADDR;
			next_s.bitIndex  = 4'h0;
			next_s.addressed = 1'b0;
			next_s.sdaLow    = 1'b0;
		end
		else if (stopCond)
		begin
			// a stop also ends any byte in flight; the next start reframes
			next_s.busBusy  = 1'b0;
			next_s.stopSeen = 1'b1;
			next_s.phase    = PH_IDLE;
			next_s.sdaLow   = 1'b0;
		end
		else if (sclRise && inFrame(s.phase))
		begin
			// the count moves on rising edges only, so the falling edge that
			// follows a start is never mistaken for the end of a bit
			if (s.bitIndex < LAST_BIT_INDEX)
			begin
				next_s.shift    = {s.shift[6:0], sdaNow};
				next_s.bitIndex = s.bitIndex + 4'h1;
			end
			else if (s.bitIndex == LAST_BIT_INDEX)
			begin
				// ninth pulse: receiver acknowledge slot
				next_s.masterAck = ~sdaNow;
				next_s.bitIndex  = afterAck();
			end
		end
		else if (sclFall && inFrame(s.phase))
		begin
			// drive changes only while clock is low to keep data stable
			next_s.sdaLow = 1'b0;
			if (s.bitIndex == LAST_BIT_INDEX)
			begin
				// eight bits in: hand the byte over, then answer in the ninth slot
				next_s.rx.valid     = 1'b1;
				next_s.rx.data      = s.shift;
				next_s.rx.isAddress = (s.phase == PH_ADDR);
				if (s.phase == PH_ADDR)
				begin
					next_s.readMode    = (s.shift[0] == DIR_READ);
					next_s.generalCall = (s.shift[7:1] == GENERAL_CALL_ADR)
						&& (s.shift[0] == DIR_WRITE) && generalCallEnable;
					next_s.addressed   = slaveReady && (next_s.generalCall
						|| (ownAddrLegal(ownAddress) && s.shift[7:1] == ownAddress));
					next_s.rx.generalCall = next_s.generalCall;
					next_s.rx.readDir     = (s.shift[0] == DIR_READ);
					next_s.sdaLow = next_s.addressed;
				end
				else
				begin
					next_s.sdaLow = s.addressed && !s.readMode && slaveReady;
				end
			end
			else if (s.bitIndex == afterAck())
			begin
				next_s.bitIndex = 4'h0;
				if (!s.addressed)
					next_s.phase = PH_IGNORE;
				else
				begin
					next_s.phase = PH_DATA;
					// a read goes on only while the master keeps acknowledging
					if (s.readMode && (s.phase == PH_ADDR || s.masterAck))
					begin
						next_s.txByte = txData;
						next_s.sdaLow = ~txBitAt(txData, 4'h0);
					end
					else if (s.readMode)
						next_s.phase = PH_IGNORE;
				end
			end
			else if (s.bitIndex != 4'h0 && s.addressed && s.readMode && s.phase == PH_DATA)
			begin
				// next bit of the read byte, placed while the clock is low
				next_s.sdaLow = ~txBitAt(s.txByte, s.bitIndex);
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			s         <= '0;
			// sync flops reset to the idle-high level so no false edge follows
			s.sclSync <= 2'h3;
			s.sdaSync <= 2'h3;
			s.sclPrev <= 1'b1;
			s.sdaPrev <= 1'b1;
			s.phase   <= PH_IDLE;
		end
		else
			s <= next_s;
	end

	// open drain only: pull low or release, never drive high
	assign sclPin        = '{out: 1'b0, oe: 1'b0};
	assign sdaPin        = '{out: 1'b0, oe: s.sdaLow};
	// status outputs come straight from registered state
	assign busBusy       = s.busBusy;
	assign startDetected = s.startSeen;
	assign stopDetected  = s.stopSeen;
	assign rxEvent       = s.rx;

endmodule

// ---- testbench/two_wire_bus_properties.sv ----
// checker: framing properties of the two-wire bus slave
module two_wire_bus_properties
	import two_wire_bus_pkg::*;
(
	// clock and control
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic       two_wire_power_gate,
	input wire logic [6:0] ownAddress,
	input wire logic       slaveReady,
	// outputs
	input od_pin_t         sclPin,
	input od_pin_t         sdaPin,
	input wire logic       busBusy,
	input wire logic       startDetected,
	input rx_event_t       rxEvent
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_adr; rxEvent.valid && rxEvent.isAddress; endsequence
	sequence s_quiet; !sdaPin.oe [*3]; endsequence
	property p_busy; startDetected |-> busBusy; endproperty
	a_busy: assert property (p_busy) else $error("start without busy");
	property p_drive; !sclPin.oe && !sdaPin.out; endproperty
	a_drive: assert property (p_drive) else $error("line driven high");
	property p_gate; two_wire_power_gate [*3] |-> !busBusy && !sdaPin.oe; endproperty
	a_gate: assert property (p_gate) else $error("active while gated");
	property p_dir; s_adr |-> rxEvent.readDir == rxEvent.data[0]; endproperty
	a_dir: assert property (p_dir) else $error("direction wrong");
	property p_nack; s_adr ##0 !slaveReady |-> s_quiet; endproperty
	a_nack: assert property (p_nack) else $error("busy slave acked");
	property p_rsvd; s_adr ##0 rxEvent.data[7:4] == RESERVED_TOP |-> s_quiet; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved address acked");
	property p_gcrd; s_adr ##0 rxEvent.data == 8'h01 |-> s_quiet; endproperty
	a_gcrd: assert property (p_gcrd) else $error("general read acked");
	property p_ack;
		s_adr ##0 (rxEvent.data[7:1] == ownAddress && slaveReady && ownAddress[6:3] != RESERVED_TOP
			&& ownAddress != GENERAL_CALL_ADR) |-> ##[0:3] sdaPin.oe;
	endproperty
	a_ack: assert property (p_ack) else $error("own address not acked");
endmodule
bind two_wire_bus_slave two_wire_bus_properties chk_u (.ref_clk, .rst_n, .two_wire_power_gate, .ownAddress,
	.slaveReady, .sclPin, .sdaPin, .busBusy, .startDetected, .rxEvent);

// ---- testbench/two_wire_bus_master_model.sv ----
// bus master model: clocks frames, drives data open-drain
module two_wire_bus_master_model
(
	// bus lines
	output logic      scl = 1'b1,
	output logic      sdaDrv = 1'b1,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 1ns;
	// clock stands still between frames
	task automatic cond(input logic first);
		scl = 1'b0;
		#160 sdaDrv = first;
		#80 scl = 1'b1;
		#80 sdaDrv = !first;
		#80;
	endtask
	task automatic bitx(input logic b, output logic s);
		scl = 1'b0;
		#80 sdaDrv = b;
		#80 scl = 1'b1;
		#80 s = sda;
		#80;
	endtask
	task automatic xfer(input logic [7:0] d, input logic mAck, output logic [7:0] rd, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bitx(d[i], s);
			rd[i] = s;
		end
		bitx(!mAck, s);
		ack = !s;
	endtask
endmodule

// ---- testbench/two_wire_bus_slave_tb.sv ----
// bench: random framed transfers against the two-wire bus slave
module two_wire_bus_framing_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import two_wire_bus_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        gate = 1'b0;
	logic [6:0]  ownAddress = 7'h2a;
	logic        gce = 1'b0;
	logic        slaveReady = 1'b1;
	logic [7:0]  txData = 8'h00;
	logic        scl;
	logic        sdaDrv;
	od_pin_t     sclPin;
	od_pin_t     sdaPin;
	logic        busBusy;
	rx_event_t   rxEvent;
	logic [7:0]  lastRx;
	logic [7:0]  rb;
	logic        ack;
	logic        expAck;
	logic [6:0]  adr;
	logic [31:0] r;
	logic        gcExp;
	logic        startPulse;
	logic        stopPulse;
	logic [9:0]  expEntry;
	logic [9:0]  expQ[$];
	int          nStart = 0;
	int          nStop = 0;
	int          expStart = 0;
	int          expStop = 0;
	int          seed = 32'h9282ce57;
	int          nErrors = 0;
	int          checkCount = 0;
	wire         sclIn = scl & ~(sclPin.oe & ~sclPin.out);
	wire         sdaIn = sdaDrv & ~(sdaPin.oe & ~sdaPin.out);
	always #20 ref_clk = ~ref_clk;
	two_wire_bus_slave dut_u (.ref_clk, .rst_n, .two_wire_power_gate(gate), .ownAddress, .generalCallEnable(gce),
		.slaveReady, .txData, .sclIn, .sdaIn, .sclPin, .sdaPin, .busBusy,
		.startDetected(startPulse), .stopDetected(stopPulse), .rxEvent);
	two_wire_bus_master_model m (.scl, .sdaDrv, .sda(sdaIn));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checkCount++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// reference model: every byte handed over is matched against the queue
	always @(negedge ref_clk)
	begin
		if (startPulse === 1'b1)
			nStart++;
		if (stopPulse === 1'b1)
			nStop++;
		if (rxEvent.valid === 1'b1)
		begin
			lastRx <= rxEvent.data;
			expEntry = (expQ.size() > 0) ? expQ.pop_front()
				: ~{rxEvent.generalCall, rxEvent.isAddress, rxEvent.data};
			check(rxEvent.data, expEntry[7:0]);
			check(8'({rxEvent.generalCall, rxEvent.isAddress}), 8'(expEntry[9:8]));
		end
	end
	task automatic printVerdict();
		if (nErrors == 0 && checkCount > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		#2000000;
		nErrors++;
		printVerdict();
	end
	initial
	begin
		repeat (6) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		for (int k = 0; k < 40; k++)
		begin
			repeat (4) @(posedge ref_clk);
			#1 r = $random(seed);
			ownAddress = (k % 5 == 4) ? {RESERVED_TOP, r[2:0]} : 7'h2a;
			gce = r[3];
			slaveReady = r[4] | r[5];
			txData = r[15:8];
			gate = (k % 9 == 8);
			adr = r[7] ? r[22:16] : (r[6] ? GENERAL_CALL_ADR : ownAddress);
			expAck = !gate && slaveReady && (adr == GENERAL_CALL_ADR ? gce && !r[24]
				: adr == ownAddress && adr[6:3] != RESERVED_TOP);
			gcExp = (adr == GENERAL_CALL_ADR) && !r[24] && gce;
			// a master granted a read must take a byte before restarting
			repeat ((r[25] && !(r[24] && expAck)) ? 2 : 1)
			begin
				if (!gate)
				begin
					expStart++;
					expQ.push_back({gcExp, 1'b1, adr, r[24]});
				end
				m.cond(1'b1);
				m.xfer({adr, r[24]}, 1'b0, rb, ack);
				check(8'(ack), 8'(expAck));
				if (!gate) check(lastRx, {adr, r[24]});
			end
			check(8'(busBusy), 8'(!gate));
			if (expAck)
			begin
				expQ.push_back({gcExp, 1'b0, r[24] ? txData : r[31:24]});
				m.xfer(r[24] ? 8'hff : r[31:24], 1'b0, rb, ack);
				check(8'(ack), 8'(!r[24]));
				if (r[24]) check(rb, txData);
				else check(lastRx, r[31:24]);
			end
			m.cond(1'b0);
			if (!gate) expStop++;
			repeat (8) @(posedge ref_clk);
			#1 check(8'(busBusy), 8'h00);
			check(8'(nStart), 8'(expStart));
			check(8'(nStop), 8'(expStop));
		end
		check(8'(expQ.size()), 8'h00);
		printVerdict();
	end
endmodule
